//--- core/analog_input_scaling_regs.vh
// register offsets, fields, reset values and timing counts of the analogue input block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef ANALOG_INPUT_SCALING_REGS_VH
`define ANALOG_INPUT_SCALING_REGS_VH
`define OFS_FUNCTION 12'h000
`define OFS_VA_MIN 12'h004
`define OFS_VA_MAX 12'h008
`define OFS_VB_MIN 12'h00C
`define OFS_VB_MAX 12'h010
`define OFS_CUR_MIN 12'h014
`define OFS_CUR_MAX 12'h018
`define OFS_LOSS 12'h01C
`define OFS_FBLIMIT 12'h020
`define OFS_THERM 12'h024
`define OFS_STATUS 12'h028
`define OFS_REFOUT 12'h02C
`define OFS_FBOUT 12'h030
`define FUNC_NONE 2'h0
`define FUNC_REF 2'h1
`define FUNC_FB 2'h2
`define FUNC_THERM 2'h3
`define VOLT_FULL 16'h2710
`define CUR_FULL 16'h4E20
`define RST_VA_MIN 16'h0000
`define RST_V_MAX 16'h2710
`define RST_CUR_MIN 16'h0FA0
`define RST_CUR_MAX 16'h4E20
`define RST_FUNC 6'h11
`define RST_TIMEOUT 7'h0A
`define TIMEOUT_MIN 7'h01
`define TIMEOUT_MAX 7'h63
`define THERM_CUTOUT 16'h0BB8
`define PROT_WARN 2'h1
`define PROT_TRIP 2'h2
`define ACT_NONE 3'h0
`define ACT_STOP_TRIP 3'h5
`define CLK_HZ 250000000
`endif

//--- core/analog_input_scaling.v
// analogue input role selection, scaling and signal-loss supervision behind an apb slave
// assumes samples in mV (voltage), uA (current) and ohm (thermistor), synchronous to clk
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "analog_input_scaling_regs.vh"
module analog_input_scaling #(
	parameter SEC_CYCLES = `CLK_HZ
) (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [15:0] voltageA,
	input wire [15:0] voltageB,
	input wire [15:0] currentIn,
	input wire [15:0] thermOhmA,
	input wire [15:0] thermOhmB,
	input wire [1:0] thermalProtection,
	input wire zoneRegulation,
	input wire busTimeout,
	input wire [2:0] busTimeoutAction,
	output reg [15:0] referenceOut,
	output reg [15:0] feedbackOut,
	output reg [2:0] activeAction,
	output reg thermistorStop
);
	reg rstMeta, rstSync;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end
	reg [5:0] funcSel_q;
	reg [15:0] minV_q [0:2];
	reg [15:0] maxV_q [0:2];
	reg [6:0] signal_loss_timeout_q;
	reg [2:0] signal_loss_action_q;
	reg [15:0] minimum_feedback_q, maximum_feedback_q, minRef_q, maxRef_q;
	reg [2:0] lossAct_q;
	reg [2:0] lossNow;
	reg [15:0] level [0:2];
	wire [1:0] fn [0:2];
	assign fn[0] = funcSel_q[1:0];
	assign fn[1] = funcSel_q[3:2];
	assign fn[2] = funcSel_q[5:4];
	always @* begin
		level[0] = voltageA;
		level[1] = voltageB;
		level[2] = currentIn;
	end
	wire wrEn = psel && penable && pwrite;
	wire [6:0] toIn = pwdata[6:0];
	integer i;
	integer j;
	// apb slave, single-cycle access
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			funcSel_q <= `RST_FUNC;
			minV_q[0] <= `RST_VA_MIN;
			minV_q[1] <= `RST_VA_MIN;
			minV_q[2] <= `RST_CUR_MIN;
			maxV_q[0] <= `RST_V_MAX;
			maxV_q[1] <= `RST_V_MAX;
			maxV_q[2] <= `RST_CUR_MAX;
			signal_loss_timeout_q <= `RST_TIMEOUT;
			signal_loss_action_q <= `ACT_NONE;
			minimum_feedback_q <= 16'h0000;
			maximum_feedback_q <= 16'hFFFF;
			minRef_q <= 16'h0000;
			maxRef_q <= 16'hFFFF;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= paddr > `OFS_FBOUT;
				case (paddr)
				`OFS_FUNCTION: prdata <= {26'h0, funcSel_q};
				`OFS_VA_MIN: prdata <= {16'h0, minV_q[0]};
				`OFS_VA_MAX: prdata <= {16'h0, maxV_q[0]};
				`OFS_VB_MIN: prdata <= {16'h0, minV_q[1]};
				`OFS_VB_MAX: prdata <= {16'h0, maxV_q[1]};
				`OFS_CUR_MIN: prdata <= {16'h0, minV_q[2]};
				`OFS_CUR_MAX: prdata <= {16'h0, maxV_q[2]};
				`OFS_LOSS: prdata <= {21'h0, signal_loss_action_q, 1'b0, signal_loss_timeout_q};
				`OFS_FBLIMIT: prdata <= {maximum_feedback_q, minimum_feedback_q};
				`OFS_THERM: prdata <= {maxRef_q, minRef_q};
				`OFS_STATUS: prdata <= {24'h0, thermistorStop, lossAct_q, 1'b0, lossNow};
				`OFS_REFOUT: prdata <= {16'h0, referenceOut};
				`OFS_FBOUT: prdata <= {16'h0, feedbackOut};
				default: prdata <= 32'h00000000;
				endcase
			end
			if (wrEn && pready) begin
				case (paddr)
				`OFS_FUNCTION: begin
					funcSel_q[3:0] <= pwdata[3:0];
					funcSel_q[5:4] <= (pwdata[5:4] == `FUNC_THERM) ? `FUNC_NONE : pwdata[5:4];
				end
				`OFS_VA_MIN: minV_q[0] <= (pwdata[15:0] > `VOLT_FULL) ? `VOLT_FULL : pwdata[15:0];
				`OFS_VA_MAX: maxV_q[0] <= (pwdata[15:0] > `VOLT_FULL) ? `VOLT_FULL : pwdata[15:0];
				`OFS_VB_MIN: minV_q[1] <= (pwdata[15:0] > `VOLT_FULL) ? `VOLT_FULL : pwdata[15:0];
				`OFS_VB_MAX: maxV_q[1] <= (pwdata[15:0] > `VOLT_FULL) ? `VOLT_FULL : pwdata[15:0];
				`OFS_CUR_MIN: minV_q[2] <= (pwdata[15:0] > `CUR_FULL) ? `CUR_FULL : pwdata[15:0];
				`OFS_CUR_MAX: maxV_q[2] <= (pwdata[15:0] > `CUR_FULL) ? `CUR_FULL : pwdata[15:0];
				`OFS_LOSS: begin
					// timeout range 1 to 99 s
					signal_loss_timeout_q <= (toIn < `TIMEOUT_MIN) ? `TIMEOUT_MIN :
						(toIn > `TIMEOUT_MAX) ? `TIMEOUT_MAX : toIn;
					if (pwdata[10:8] <= `ACT_STOP_TRIP)
						signal_loss_action_q <= pwdata[10:8];
				end
				`OFS_FBLIMIT: begin
					minimum_feedback_q <= pwdata[15:0];
					maximum_feedback_q <= pwdata[31:16];
				end
				`OFS_THERM: begin
					minRef_q <= pwdata[15:0];
					maxRef_q <= pwdata[31:16];
				end
				default: ;
				endcase
			end
		end
	end
	// linear map from scaling points to output span
	reg [15:0] scaled [0:2];
	reg [31:0] num;
	reg [31:0] quo;
	reg [15:0] span, lo, hi;
	reg [17:0] refSum, fbSum;
	always @* begin
		refSum = 18'h00000;
		fbSum = 18'h00000;
		num = 32'h00000000;
		quo = 32'h00000000;
		span = 16'h0000;
		lo = 16'h0000;
		hi = 16'h0000;
		lossNow = 3'h0;
		for (i = 0; i < 3; i = i + 1) begin
			lo = (fn[i] == `FUNC_FB) ? minimum_feedback_q : minRef_q;
			hi = (fn[i] == `FUNC_FB) ? maximum_feedback_q : maxRef_q;
			span = maxV_q[i] - minV_q[i];
			if (maxV_q[i] <= minV_q[i] || level[i] <= minV_q[i])
				scaled[i] = lo;
			else if (level[i] >= maxV_q[i])
				scaled[i] = hi;
			else begin
				num = (level[i] - minV_q[i]) * (hi - lo);
				quo = num / {16'h0000, span};
				scaled[i] = lo + quo[15:0];
			end
			lossNow[i] = (fn[i] == `FUNC_REF || fn[i] == `FUNC_FB) && ({1'b0, level[i]} < ({1'b0, minV_q[i]} >> 1));
			// ignored inputs add nothing, references summed
			if (fn[i] == `FUNC_REF)
				refSum = refSum + {2'b00, scaled[i]};
			// zone regulation takes feedback from voltage inputs only
			if (fn[i] == `FUNC_FB && !(zoneRegulation && i == 2))
				fbSum = fbSum + {2'b00, scaled[i]};
		end
	end
	reg [31:0] secCnt_q [0:2];
	reg [6:0] secs_q [0:2];
	reg [2:0] expired_q;
	always @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			for (j = 0; j < 3; j = j + 1) begin
				secCnt_q[j] <= 32'h00000000;
				secs_q[j] <= 7'h00;
			end
			expired_q <= 3'h0;
			lossAct_q <= `ACT_NONE;
			referenceOut <= 16'h0000;
			feedbackOut <= 16'h0000;
			activeAction <= `ACT_NONE;
			thermistorStop <= 1'b0;
		end else begin
			for (j = 0; j < 3; j = j + 1) begin
				if (!lossNow[j]) begin
					secCnt_q[j] <= 32'h00000000;
					secs_q[j] <= 7'h00;
					expired_q[j] <= 1'b0;
				end else if (!expired_q[j]) begin
					if (secs_q[j] >= signal_loss_timeout_q)
						expired_q[j] <= 1'b1;
					else if (secCnt_q[j] == SEC_CYCLES - 1) begin
						secCnt_q[j] <= 32'h00000000;
						secs_q[j] <= secs_q[j] + 7'h01;
					end else
						secCnt_q[j] <= secCnt_q[j] + 32'h00000001;
				end
			end
			lossAct_q <= (|expired_q) ? signal_loss_action_q : `ACT_NONE;
			// analogue loss wins over bus timeout when its action is not none
			if ((|expired_q) && signal_loss_action_q != `ACT_NONE)
				activeAction <= signal_loss_action_q;
			else if (busTimeout)
				activeAction <= busTimeoutAction;
			else
				activeAction <= `ACT_NONE;
			referenceOut <= (refSum > 18'h0FFFF) ? 16'hFFFF : refSum[15:0];
			feedbackOut <= (fbSum > 18'h0FFFF) ? 16'hFFFF : fbSum[15:0];
			thermistorStop <= (thermalProtection == `PROT_WARN || thermalProtection == `PROT_TRIP) &&
				((fn[0] == `FUNC_THERM && thermOhmA > `THERM_CUTOUT) ||
				(fn[1] == `FUNC_THERM && thermOhmB > `THERM_CUTOUT));
		end
	end
endmodule // analog_input_scaling

//--- dv/sensor_front.sv
// sensor and thermistor sources on the analogue pins
// assumes the bench sets levels; they reach the pins one edge later
`timescale 1ns/1ps
module sensor_front (
	input wire clk,
	input wire [15:0] setA,
	input wire [15:0] setB,
	input wire [15:0] setC,
	input wire [15:0] setT,
	output reg [15:0] voltageA,
	output reg [15:0] voltageB,
	output reg [15:0] currentIn,
	output reg [15:0] thermOhmA,
	output reg [15:0] thermOhmB
);
	always @(posedge clk) begin
		voltageA <= setA;
		voltageB <= setB;
		currentIn <= setC;
		thermOhmA <= setT;
		thermOhmB <= setT;
	end
endmodule // sensor_front

//--- dv/analog_input_scaling_sva.sv
// assertions on the apb answer and the supervision outputs
// assumes binding to analog_input_scaling
`timescale 1ns/1ps
module analog_input_scaling_chk (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [15:0] thermOhmA,
	input wire [15:0] thermOhmB,
	input wire [1:0] thermalProtection,
	input wire [2:0] activeAction,
	input wire thermistorStop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray slverr");
	chk_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h030)) else $error("slverr wrong");
	chk_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
	chk_action_code: assert property (activeAction <= 3'h5) else $error("bad action");
	chk_therm_prot: assert property ((!(thermalProtection inside {2'h1, 2'h2}))[*2] |-> !thermistorStop)
		else $error("stop without protection");
	chk_therm_cutout: assert property ((thermOhmA <= 16'h0BB8 && thermOhmB <= 16'h0BB8)[*2] |-> !thermistorStop)
		else $error("stop below cutout");
	cover property (activeAction == 3'h5);
	cover property (thermistorStop);
	cover property (pslverr);
endmodule // analog_input_scaling_chk
bind analog_input_scaling analog_input_scaling_chk u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .thermOhmA(thermOhmA),
	.thermOhmB(thermOhmB), .thermalProtection(thermalProtection), .activeAction(activeAction),
	.thermistorStop(thermistorStop));

//--- dv/analog_input_scaling_tb.sv
// self-checking bench for the analogue input block
// assumes sensor_front on the analogue pins and the bound checker
`timescale 1ns/1ps
module analog_input_scaling_tb;
	reg clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, zone = 1'b0, busTo = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd;
	reg [31:0] ex;
	reg [2:0] busAct = 3'h0;
	reg [15:0] sA = 16'h0, sB = 16'h0, sC = 16'h0FA0, tA = 16'h0;
	reg [1:0] prot = 2'h0;
	wire [31:0] prdata;
	wire pready, pslverr, tStop;
	wire [15:0] vA, vB, cI, oA, oB, refO, fbO;
	wire [2:0] act;
	integer n_fail = 0, n_checks = 0, seed = 32'hC809, i;
	reg [11:0] rA [0:5] = '{12'h000, 12'h004, 12'h008, 12'h014, 12'h018, 12'h01C};
	reg [31:0] rV [0:5] = '{32'h11, 32'h0, 32'h2710, 32'h0FA0, 32'h4E20, 32'h0A};
	sensor_front u_sensor_front (.clk(clk), .setA(sA), .setB(sB), .setC(sC), .setT(tA), .voltageA(vA),
		.voltageB(vB), .currentIn(cI), .thermOhmA(oA), .thermOhmB(oB));
	analog_input_scaling #(.SEC_CYCLES(10)) u_analog_input_scaling (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .voltageA(vA), .voltageB(vB), .currentIn(cI), .thermOhmA(oA), .thermOhmB(oB),
		.thermalProtection(prot), .zoneRegulation(zone), .busTimeout(busTo), .busTimeoutAction(busAct),
		.referenceOut(refO), .feedbackOut(fbO), .activeAction(act), .thermistorStop(tStop));
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k = k + 1;
			end while (pready !== 1'b1 && k < 20);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (pready !== 1'b1) begin
				n_fail = n_fail + 1;
				$display("Error t=%0t pready %h exp %h", $time, pready, 1'b1);
				wrap_up;
			end
		end
	endtask
	function [15:0] scale(input [15:0] x, input [15:0] mn, input [15:0] mx, input [15:0] lo, input [15:0] hi);
		reg [31:0] t;
		begin
			t = 32'h0;
			if (mx <= mn || x <= mn)
				scale = lo;
			else if (x >= mx)
				scale = hi;
			else begin
				t = ({16'h0, x} - {16'h0, mn}) * ({16'h0, hi} - {16'h0, lo}) / ({16'h0, mx} - {16'h0, mn});
				scale = lo + t[15:0];
			end
		end
	endfunction
	function [31:0] sat(input [31:0] v);
		sat = (v > 32'hFFFF) ? 32'hFFFF : v;
	endfunction
	initial forever #2 clk = ~clk;
	initial begin
		wt(10);
		rst_b <= 1'b1;
		wt(3);
		for (i = 0; i < 6; i = i + 1) begin
			apb(1'b0, rA[i], 32'h0);
			cmp(rd, rV[i]);
		end
		apb(1'b0, 12'h034, 32'h0);
		cmp({31'h0, er}, 32'h1);
		cmp(rd, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			sA <= $unsigned($random(seed)) % 10001;
			sB <= $unsigned($random(seed)) % 10001;
			sC <= i[0] ? 16'h4E20 : 16'h0FA0;
			wt(4);
			ex = scale(sA, 16'h0, 16'h2710, 16'h0, 16'hFFFF) + scale(sC, 16'h0FA0, 16'h4E20, 16'h0, 16'hFFFF);
			cmp(refO, sat(ex));
		end
		apb(1'b1, 12'h000, 32'h05);
		apb(1'b1, 12'h024, 32'h10000100);
		sA <= 16'h0000;
		sB <= 16'h2710;
		sC <= $unsigned($random(seed)) % 20001;
		wt(4);
		ex = scale(sA, 16'h0, 16'h2710, 16'h0100, 16'h1000) + scale(sB, 16'h0, 16'h2710, 16'h0100, 16'h1000);
		cmp(refO, ex);
		apb(1'b0, 12'h02C, 32'h0);
		cmp(rd, 32'h1100);
		apb(1'b1, 12'h008, 32'hFFFF);
		apb(1'b0, 12'h008, 32'h0);
		cmp(rd, 32'h2710);
		apb(1'b1, 12'h018, 32'hFFFF);
		apb(1'b0, 12'h018, 32'h0);
		cmp(rd, 32'h4E20);
		apb(1'b1, 12'h01C, 32'h0700);
		apb(1'b0, 12'h01C, 32'h0);
		cmp(rd, 32'h01);
		apb(1'b1, 12'h000, 32'h20);
		apb(1'b1, 12'h020, 32'h20000200);
		sC <= 16'h4E20;
		wt(4);
		cmp(fbO, 32'h2000);
		zone <= 1'b1;
		wt(4);
		cmp(fbO, 32'h0);
		zone <= 1'b0;
		apb(1'b1, 12'h000, 32'h03);
		for (i = 0; i < 4; i = i + 1) begin
			prot <= i[1:0];
			tA <= 16'h0BB9;
			wt(4);
			cmp(tStop, i == 1 || i == 2);
		end
		prot <= 2'h1;
		apb(1'b1, 12'h000, 32'h0C);
		wt(4);
		cmp(tStop, 32'h1);
		tA <= 16'h0BB8;
		wt(4);
		cmp(tStop, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			sA <= 16'h1388;
			rst_b <= 1'b0;
			wt(2);
			rst_b <= 1'b1;
			wt(3);
			apb(1'b1, 12'h000, 32'h01);
			apb(1'b1, 12'h004, 32'h07D0);
			apb(1'b1, 12'h01C, i * 256 + 1);
			busAct <= 3'h5 - i[2:0];
			busTo <= 1'b1;
			sA <= 16'h03E7;
			wt(8);
			sA <= 16'h03E8;
			wt(4);
			sA <= 16'h03E7;
			wt(13);
			cmp(act, 3'h5 - i[2:0]);
			wt(1);
			cmp(act, (i != 0) ? i : 5);
			busTo <= 1'b0;
		end
		apb(1'b1, 12'h000, 32'h10);
		apb(1'b1, 12'h014, 32'h0BB8);
		apb(1'b1, 12'h01C, 32'h0201);
		sC <= 16'h05DB;
		wt(30);
		cmp(act, 32'h2);
		apb(1'b0, 12'h028, 32'h0);
		cmp(rd, 32'h24);
		wrap_up;
	end
endmodule // analog_input_scaling_tb
